// file: rtl/word_load_mask_exec.sv
// Purpose: Executes indexed word loads and the two mask operations
// Assumes: Software writes instruction words and operands over APB
// Notes: One load in flight; an instruction write stalls while busy
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps

// Operation
// - Opcode 31 with extended code 55 is the updating indexed word load into the target.
// - The address is the index register alone for base field 0, else base plus index.
// - The base gets the address only if nonzero, not the target, and the load did not fault.
// - Both indexed loads leave the exception register and condition field 0 alone.
// - Opcode 31 with extended code 23 is the plain indexed load, writing only the target.
// - Opcode 31 with extended code 29 is mask generation into the target, bit 31 records.
// - Mask start comes from the low five bits of the source, end from those of the index.
// - With start below end plus one, ones fill start through end and zeros elsewhere.
// - With start equal to end plus one, all 32 mask bits are ones.
// - With start above end plus one, zeros fill end plus one through start minus one.
// - Opcode 31 with extended code 541 copies source bits into the target where the index operand, used as the mask, is one.
// - During mask insert, target bits under a zero mask bit keep their value.
// - A set record flag loads condition field 0 from the mask result, a clear one leaves it.
// - Neither mask operation touches the exception register.
// - The mask operations exist only while the legacy variant is selected.
module word_load_mask_exec import word_load_mask_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [XLEN-1:0] pwdata,
  output logic [XLEN-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Data storage access
  output logic mem_req,
  output logic [XLEN-1:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [XLEN-1:0] mem_rdata,
  input wire logic mem_err
);

  typedef enum logic {IDLE, LOAD_WAIT} exec_state_e;

  typedef struct packed {
    exec_state_e mode;
    logic [NUM_GPR-1:0][XLEN-1:0] gpr;
    logic [3:0] cr0;
    logic xer_so;
    logic legacy_en;
    logic [REG_FIELD_W-1:0] gpr_idx;
    logic [XLEN-1:0] mem_addr;
    logic [REG_FIELD_W-1:0] pend_tgt;
    logic [REG_FIELD_W-1:0] pend_base;
    logic pend_upd;
    logic illegal;
    logic align_flt;
    logic dsi_flt;
  } core_s;

  core_s state_reg;
  core_s state_next;

  // Pull a register-number field out of an instruction word
  function automatic logic [REG_FIELD_W-1:0] reg_field(input logic [XLEN-1:0] w,
                                                       input int lsb);
    reg_field = REG_FIELD_W'(w >> lsb);
  endfunction : reg_field

  // Signed compare of a result against zero, with the summary overflow copy
  function automatic logic [3:0] cond_of(input logic [XLEN-1:0] r, input logic so);
    logic [3:0] c;
    c = 4'h0;
    // Signed view: a set top bit is negative, never greater than zero
    c[CR_NEG_BIT] = r[XLEN-1];
    c[CR_POS_BIT] = !r[XLEN-1] && (r != WORD_RESET);
    c[CR_ZERO_BIT] = (r == WORD_RESET);
    c[CR_SO_BIT] = so;
    cond_of = c;
  endfunction : cond_of

  // Field decode of the word being written to the instruction register
  logic [OPC_W-1:0] opc_f;
  logic [XO_W-1:0] xo_f;
  logic [REG_FIELD_W-1:0] tgt_f;
  logic [REG_FIELD_W-1:0] base_f;
  logic [REG_FIELD_W-1:0] idx_f;
  logic rec_f;
  assign opc_f = OPC_W'(pwdata >> OPC_LSB);
  assign xo_f = XO_W'(pwdata >> XO_LSB);
  assign tgt_f = reg_field(pwdata, TGT_LSB);
  assign base_f = reg_field(pwdata, BASE_LSB);
  assign idx_f = reg_field(pwdata, IDX_LSB);
  assign rec_f = pwdata[REC_BIT];

  logic is_ld_upd;
  logic is_ld;
  logic is_mgen;
  logic is_mins;
  logic mask_ok;
  assign is_ld_upd = (opc_f == OP_PRIMARY) && (xo_f == XO_LOAD_UPD);
  assign is_ld = (opc_f == OP_PRIMARY) && (xo_f == XO_LOAD);
  assign is_mgen = (opc_f == OP_PRIMARY) && (xo_f == XO_MASK_GEN);
  assign is_mins = (opc_f == OP_PRIMARY) && (xo_f == XO_MASK_INS);
  // Mask operations are only recognised in the legacy variant
  assign mask_ok = state_reg.legacy_en;

  // Operand reads; the source field sits where a load keeps its target
  logic [XLEN-1:0] src_val;
  logic [XLEN-1:0] base_raw;
  logic [XLEN-1:0] idx_val;
  logic [XLEN-1:0] eff_addr;
  assign src_val = state_reg.gpr[tgt_f];
  assign base_raw = state_reg.gpr[base_f];
  assign idx_val = state_reg.gpr[idx_f];
  assign eff_addr = ((base_f == '0) ? WORD_RESET : base_raw) + idx_val;

  // Mask from the low five bits of source and index operands
  logic [XLEN-1:0] mask_w;
  logic [XLEN-1:0] ins_w;
  mask_span_gen u_mask (
    .start_pos(src_val[REG_FIELD_W-1:0]),
    .end_pos(idx_val[REG_FIELD_W-1:0]),
    .mask_out(mask_w)
  );
  // Target bits under a zero mask bit come back unchanged
  assign ins_w = (src_val & idx_val) | (base_raw & ~idx_val);

  // APB handshake: an instruction write waits out a pending load
  logic acc;
  logic busy;
  logic mapped;
  logic wr_fire;
  logic instr_go;
  assign busy = (state_reg.mode == LOAD_WAIT);
  assign acc = psel && penable;
  // Stalling the bus, not queueing, keeps one load in flight with no buffer
  assign pready = !(acc && pwrite && (paddr == INSTR_OFF) && busy);
  assign wr_fire = acc && pwrite && pready;
  assign instr_go = wr_fire && (paddr == INSTR_OFF);
  assign mapped = (paddr == CTRL_OFF) || (paddr == INSTR_OFF) || (paddr == STATUS_OFF) ||
                  (paddr == GPR_IDX_OFF) || (paddr == GPR_DATA_OFF) ||
                  (paddr == COND_OFF) || (paddr == ADDR_OFF);
  assign pslverr = acc && pready && !mapped;

  // Read data mux; unmapped and write-only locations read as zero
  always_comb begin
    prdata = WORD_RESET;
    if (acc && !pwrite) begin
      case (paddr)
        CTRL_OFF: prdata[CTRL_LEGACY_BIT] = state_reg.legacy_en;
        STATUS_OFF: begin
          prdata[ST_BUSY_BIT] = busy;
          prdata[ST_ILLEGAL_BIT] = state_reg.illegal;
          prdata[ST_ALIGN_BIT] = state_reg.align_flt;
          prdata[ST_DSI_BIT] = state_reg.dsi_flt;
        end
        GPR_IDX_OFF: prdata[REG_FIELD_W-1:0] = state_reg.gpr_idx;
        GPR_DATA_OFF: prdata = state_reg.gpr[state_reg.gpr_idx];
        COND_OFF: begin
          prdata[3:0] = state_reg.cr0;
          prdata[COND_SO_BIT] = state_reg.xer_so;
        end
        ADDR_OFF: prdata = state_reg.mem_addr;
        default: prdata = WORD_RESET;
      endcase
    end
  end

  // Request and address come straight from flops, so both hold until acknowledged
  assign mem_req = busy;
  assign mem_addr = state_reg.mem_addr;

  // Next state: software writes first, hardware events after so they win
  always_comb begin
    state_next = state_reg;
    if (wr_fire) begin
      case (paddr)
        CTRL_OFF: state_next.legacy_en = pwdata[CTRL_LEGACY_BIT];
        STATUS_OFF: begin
          if (pwdata[ST_ILLEGAL_BIT]) state_next.illegal = 1'b0;
          if (pwdata[ST_ALIGN_BIT]) state_next.align_flt = 1'b0;
          if (pwdata[ST_DSI_BIT]) state_next.dsi_flt = 1'b0;
        end
        GPR_IDX_OFF: state_next.gpr_idx = pwdata[REG_FIELD_W-1:0];
        GPR_DATA_OFF: state_next.gpr[state_reg.gpr_idx] = pwdata;
        COND_OFF: begin
          state_next.cr0 = pwdata[3:0];
          state_next.xer_so = pwdata[COND_SO_BIT];
        end
        default: ;
      endcase
    end
    unique case (state_reg.mode)
      IDLE: begin
        if (instr_go) begin
          if (is_ld_upd || is_ld) begin
            // A misaligned word access faults before any storage access
            if (eff_addr[1:0] != 2'b00) begin
              state_next.align_flt = 1'b1;
            end else begin
              state_next.mode = LOAD_WAIT;
              state_next.mem_addr = eff_addr;
              state_next.pend_tgt = tgt_f;
              state_next.pend_base = base_f;
              // Invalid update forms simply skip the base write
              state_next.pend_upd = is_ld_upd && (base_f != '0) && (base_f != tgt_f);
            end
          end else if ((is_mgen || is_mins) && mask_ok) begin
            // Target is the base field; the exception register is left alone
            state_next.gpr[base_f] = is_mgen ? mask_w : ins_w;
            if (rec_f) begin
              state_next.cr0 = cond_of(is_mgen ? mask_w : ins_w, state_reg.xer_so);
            end
          end else begin
            state_next.illegal = 1'b1;
          end
        end
      end
      LOAD_WAIT: begin
        if (mem_ack) begin
          state_next.mode = IDLE;
          if (mem_err) begin
            state_next.dsi_flt = 1'b1;
          end else begin
            // Condition field and exception register are not written here
            state_next.gpr[state_reg.pend_tgt] = mem_rdata;
            // Issue refused a base equal to the target, so the two writes never collide
            if (state_reg.pend_upd) begin
              state_next.gpr[state_reg.pend_base] = state_reg.mem_addr;
            end
          end
        end
      end
    endcase
  end

  // State register; the reset values are constants only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
      state_reg.mode <= IDLE;
      state_reg.legacy_en <= LEGACY_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Checks on the execute behaviour
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [5:0] start_x;
  logic [5:0] end_x;
  assign start_x = {1'b0, src_val[REG_FIELD_W-1:0]};
  assign end_x = {1'b0, idx_val[REG_FIELD_W-1:0]};

  // Load issue and completion
  load_issue_a: assert property (
    instr_go && !busy && is_ld_upd && (eff_addr[1:0] == 2'b00)
    |=> mem_req && (mem_addr == $past(eff_addr)) && (state_reg.pend_tgt == $past(tgt_f)))
    else $error("update load not issued");

  addr_zero_base_a: assert property (
    instr_go && !busy && (is_ld || is_ld_upd) && (base_f == '0) && (eff_addr[1:0] == 2'b00)
    |=> mem_addr == $past(idx_val))
    else $error("address with zero base field wrong");

  base_update_a: assert property (
    mem_req && mem_ack && !mem_err && state_reg.pend_upd && !wr_fire
    |=> state_reg.gpr[$past(state_reg.pend_base)] == $past(mem_addr))
    else $error("base register not updated");

  fault_hold_a: assert property (
    mem_req && mem_ack && mem_err && !wr_fire
    |=> $stable(state_reg.gpr) && state_reg.dsi_flt && !mem_req)
    else $error("faulted load changed registers");

  load_flags_a: assert property (
    mem_req && mem_ack && !wr_fire |=> $stable(state_reg.cr0) && $stable(state_reg.xer_so))
    else $error("load touched condition or exception bits");

  plain_load_a: assert property (
    mem_req && mem_ack && !mem_err && !state_reg.pend_upd && !wr_fire
    |=> state_reg.gpr[$past(state_reg.pend_tgt)] == $past(mem_rdata))
    else $error("loaded word not written to target");

  req_hold_a: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("storage request dropped before acknowledge");

  align_fault_a: assert property (
    instr_go && (is_ld || is_ld_upd) && (eff_addr[1:0] != 2'b00)
    |=> !mem_req && state_reg.align_flt && $stable(state_reg.gpr))
    else $error("misaligned load not refused");

  // Mask operation checks
  mgen_write_a: assert property (
    instr_go && !busy && is_mgen && mask_ok
    |=> state_reg.gpr[$past(base_f)] == $past(mask_w))
    else $error("generated mask not written");

  mask_span_a: assert property (
    start_x < end_x + 6'd1
    |-> mask_w[XLEN-1-int'(start_x)] && mask_w[XLEN-1-int'(end_x)] &&
        ($countones(mask_w) == int'(end_x) - int'(start_x) + 1))
    else $error("forward mask span wrong");

  mask_full_a: assert property (
    start_x == end_x + 6'd1 |-> mask_w == 32'hffff_ffff)
    else $error("mask not all ones");

  mask_hole_a: assert property (
    start_x > end_x + 6'd1
    |-> !mask_w[XLEN-2-int'(end_x)] && !mask_w[XLEN-int'(start_x)] &&
        ($countones(mask_w) == XLEN - (int'(start_x) - int'(end_x) - 1)))
    else $error("wrapped mask hole wrong");

  mask_insert_a: assert property (
    instr_go && !busy && is_mins && mask_ok
    |=> state_reg.gpr[$past(base_f)] ==
        (($past(src_val) & $past(idx_val)) | ($past(base_raw) & ~$past(idx_val))))
    else $error("mask insert result wrong");

  insert_keep_a: assert property (
    instr_go && !busy && is_mins && mask_ok
    |=> ((state_reg.gpr[$past(base_f)] ^ $past(base_raw)) & ~$past(idx_val)) == WORD_RESET)
    else $error("insert changed bits outside the mask");

  record_a: assert property (
    instr_go && !busy && (is_mgen || is_mins) && mask_ok && rec_f
    |=> (state_reg.cr0[CR_ZERO_BIT] == (state_reg.gpr[$past(base_f)] == WORD_RESET)) &&
        (state_reg.cr0[CR_NEG_BIT] == state_reg.gpr[$past(base_f)][XLEN-1]) &&
        (state_reg.cr0[CR_POS_BIT] == (!state_reg.gpr[$past(base_f)][XLEN-1] &&
                                       (state_reg.gpr[$past(base_f)] != WORD_RESET))) &&
        (state_reg.cr0[CR_SO_BIT] == state_reg.xer_so))
    else $error("condition field not recorded");

  no_record_a: assert property (
    instr_go && !busy && (is_mgen || is_mins) && !rec_f |=> $stable(state_reg.cr0))
    else $error("condition field changed without record");

  mask_xer_a: assert property (
    instr_go && !busy && (is_mgen || is_mins) |=> $stable(state_reg.xer_so))
    else $error("mask operation changed exception bit");

  legacy_off_a: assert property (
    instr_go && !busy && (is_mgen || is_mins) && !mask_ok
    |=> state_reg.illegal && $stable(state_reg.gpr))
    else $error("mask operation ran outside legacy variant");

  unknown_op_a: assert property (
    instr_go && !(is_ld_upd || is_ld || is_mgen || is_mins)
    |=> state_reg.illegal && $stable(state_reg.gpr) && !mem_req)
    else $error("unknown operation not refused");

  // Main scenarios
  upd_done_c: cover property (mem_req && mem_ack && !mem_err && state_reg.pend_upd);
  wrap_mask_c: cover property (instr_go && is_mgen && mask_ok && (start_x > end_x + 6'd1));
  ins_rec_c: cover property (instr_go && is_mins && mask_ok && rec_f);
  align_c: cover property (instr_go && (is_ld || is_ld_upd) && (eff_addr[1:0] != 2'b00));
  load_fault_c: cover property (mem_req && mem_ack && mem_err);

endmodule : word_load_mask_exec

// file: rtl/word_load_mask_pkg.sv
// Purpose: Shared constants for the indexed word load and mask execute block
// Assumes: 32-bit data, APB register access, bit 0 of every word is its MSB
// Notes: Register offsets are byte addresses of aligned 32-bit words
package word_load_mask_pkg;

  // Data and register file sizes
  localparam int XLEN = 32;
  localparam int NUM_GPR = 32;
  localparam int REG_FIELD_W = 5;
  localparam int XO_W = 10;
  localparam int OPC_W = 6;

  // Instruction field positions, given as the LSB of each field
  localparam int OPC_LSB = 26;
  localparam int TGT_LSB = 21;
  localparam int BASE_LSB = 16;
  localparam int IDX_LSB = 11;
  localparam int XO_LSB = 1;
  localparam int REC_BIT = 0;

  // Opcode values
  localparam logic [OPC_W-1:0] OP_PRIMARY = 6'h1f;
  localparam logic [XO_W-1:0] XO_LOAD_UPD = 10'h037;
  localparam logic [XO_W-1:0] XO_LOAD = 10'h017;
  localparam logic [XO_W-1:0] XO_MASK_GEN = 10'h01d;
  localparam logic [XO_W-1:0] XO_MASK_INS = 10'h21d;

  // Condition field 0 layout, four bits in MSB-first order
  localparam int CR_NEG_BIT = 3;
  localparam int CR_POS_BIT = 2;
  localparam int CR_ZERO_BIT = 1;
  localparam int CR_SO_BIT = 0;

  // Register offsets
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] INSTR_OFF = 12'h004;
  localparam logic [11:0] STATUS_OFF = 12'h008;
  localparam logic [11:0] GPR_IDX_OFF = 12'h00c;
  localparam logic [11:0] GPR_DATA_OFF = 12'h010;
  localparam logic [11:0] COND_OFF = 12'h014;
  localparam logic [11:0] ADDR_OFF = 12'h018;

  // Field positions inside registers
  localparam int CTRL_LEGACY_BIT = 0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_ILLEGAL_BIT = 1;
  localparam int ST_ALIGN_BIT = 2;
  localparam int ST_DSI_BIT = 3;
  localparam int COND_SO_BIT = 8;

  // Values after reset
  localparam logic LEGACY_RESET = 1'b1;
  localparam logic [XLEN-1:0] WORD_RESET = 32'h0000_0000;

endpackage : word_load_mask_pkg

// file: rtl/mask_span_gen.sv
// Purpose: Builds the 32-bit mask between a start and an end bit position
// Assumes: Positions count from bit 0 as the most significant bit
// Notes: Purely combinational, one gate cone per mask bit
`timescale 1ns/1ps
module mask_span_gen import word_load_mask_pkg::*; (
  // Positions
  input wire logic [REG_FIELD_W-1:0] start_pos,
  input wire logic [REG_FIELD_W-1:0] end_pos,
  // Result
  output logic [XLEN-1:0] mask_out
);

  // Forward span when start does not pass end, wrapped span otherwise;
  // start equal to end plus one falls in the wrapped case and fills all bits
  for (genvar i = 0; i < XLEN; i++) begin : g_bit
    localparam logic [REG_FIELD_W-1:0] POS = REG_FIELD_W'(i);
    assign mask_out[XLEN-1-i] = (start_pos <= end_pos) ?
                                ((POS >= start_pos) && (POS <= end_pos)) :
                                ((POS >= start_pos) || (POS <= end_pos));
  end

endmodule : mask_span_gen

// file: verif/storage_model.sv
// Purpose: Behavioural data storage on the far side of the word load link
// Assumes: One request at a time, answered by a one-cycle acknowledge
// Notes: Read data is the inverted address, so each load is traceable
`timescale 1ns/1ps
module storage_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench control
  input wire logic [3:0] wait_cycles,
  input wire logic fail_next,
  // Storage link
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  output logic mem_err
);
  logic [3:0] wait_cnt;

  // Answer after the set wait; idle lines toggle so stale data never matches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= 4'h0;
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0000_0000;
      mem_err <= 1'b0;
    end else if (mem_req && !mem_ack && wait_cnt == wait_cycles) begin
      wait_cnt <= 4'h0;
      mem_ack <= 1'b1;
      mem_rdata <= ~mem_addr;
      mem_err <= fail_next;
    end else begin
      wait_cnt <= (mem_req && !mem_ack) ? wait_cnt + 4'h1 : 4'h0;
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      mem_err <= ~mem_err;
    end
  end
endmodule : storage_model

// file: verif/tb.sv
// Purpose: Self-checking bench for the indexed load and mask execute block
// Assumes: APB master tasks, storage model on the far side
// Notes: Each instruction but the first of the back-to-back pair is written and then polled until not busy
`timescale 1ns/1ps
module tb import word_load_mask_pkg::*; ();
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [XLEN-1:0] pwdata, prdata, mem_addr, mem_rdata, rd;
  logic mem_req, mem_ack, mem_err, fail_next, rd_err;
  logic [3:0] wait_cycles;
  logic [31:0] tv[10], sv[10], bv[10], ev[10];
  int err_count, checks_done;

  word_load_mask_exec u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .mem_err(mem_err));
  storage_model u_mem (.pclk(pclk), .presetn(presetn), .wait_cycles(wait_cycles),
    .fail_next(fail_next), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .mem_err(mem_err));

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // One APB transfer; answer lines are read in the access cycle, where they
  // are settled, so the closing edge's own register update cannot race them
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    logic rdy;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(negedge pclk);
      rdy = pready;
      rd = prdata;
      rd_err = pslverr;
      @(posedge pclk);
      n++;
    end while (rdy !== 1'b1 && n < 100);
    psel <= 1'b0;
    penable <= 1'b0;
    if (rdy !== 1'b1) begin
      chk(32'h0000_0000, 32'h0000_0001, "pready timeout");
      conclude();
    end
  endtask : apb

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp, what);
  endtask : rd_chk

  task automatic set_gpr(input logic [31:0] i, input logic [31:0] v);
    apb(1'b1, GPR_IDX_OFF, i);
    apb(1'b1, GPR_DATA_OFF, v);
  endtask : set_gpr

  task automatic gpr_chk(input logic [31:0] i, input logic [31:0] exp, input string what);
    apb(1'b1, GPR_IDX_OFF, i);
    rd_chk(GPR_DATA_OFF, exp, what);
  endtask : gpr_chk

  function automatic logic [31:0] mk(input logic [4:0] t, input logic [4:0] a,
    input logic [4:0] b, input logic [9:0] xo, input logic rc);
    return {OP_PRIMARY, t, a, b, xo, rc};
  endfunction : mk

  // Issue an instruction, then poll busy under a bound
  task automatic run(input logic [31:0] ins);
    int n;
    apb(1'b1, INSTR_OFF, ins);
    n = 0;
    do begin
      apb(1'b0, STATUS_OFF, 32'h0000_0000);
      n++;
    end while (rd[ST_BUSY_BIT] !== 1'b0 && n < 50);
    if (n >= 50) begin
      chk(32'h0000_0000, 32'h0000_0001, "busy timeout");
      conclude();
    end
  endtask : run

  // Free-running 250 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Main sequence
  initial begin
    int i;
    logic [31:0] pre, ec;
    logic so;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    wait_cycles = 4'h0;
    fail_next = 1'b0;
    err_count = 0;
    checks_done = 0;
    // Mask table: six generate cases then four insert cases
    tv = '{32'h1234_5678, 32'h1234_5678, 32'h1234_5678, 32'h1234_5678, 32'h1234_5678,
      32'h1234_5678, 32'hAAAA_AAAA, 32'hAAAA_AAAA, 32'h0000_0000, 32'h8000_0000};
    sv = '{32'hABCD_EF10, 32'h0000_0017, 32'h0000_0005, 32'h0000_0000, 32'h0000_001f,
      32'h0000_0003, 32'h5555_5555, 32'h5555_5555, 32'h0000_0001, 32'h0000_0000};
    bv = '{32'h0000_0014, 32'hFFFF_FFF0, 32'h0000_0004, 32'h0000_001f, 32'h0000_0000,
      32'h0000_0003, 32'h000F_0F00, 32'h0A05_0F00, 32'hFFFF_FFFF, 32'h8000_0000};
    ev = '{32'h0000_F800, 32'hFFFF_81FF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h8000_0001,
      32'h1000_0000, 32'hAAA5_A5AA, 32'hA0AF_A5AA, 32'h0000_0001, 32'h0000_0000};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(CTRL_OFF, 32'h0000_0001, "ctrl reset");
    rd_chk(ADDR_OFF, 32'h0000_0000, "address reset");
    apb(1'b0, 12'h040, 32'h0000_0000);
    chk({31'h0000_0000, rd_err}, 32'h0000_0001, "unmapped error");
    // Plain load with base field 0 uses the index alone
    set_gpr(0, 32'h0000_0f00);
    set_gpr(5, 32'h0000_0100);
    set_gpr(4, 32'h0000_0200);
    apb(1'b1, COND_OFF, 32'h0000_0109);
    run(mk(5'd6, 5'd0, 5'd5, XO_LOAD, 1'b0));
    gpr_chk(6, ~32'h0000_0100, "plain load data");
    rd_chk(ADDR_OFF, 32'h0000_0100, "address base zero");
    // Back-to-back: the second write stalls behind a slow answer
    set_gpr(5, 32'h0000_0040);
    wait_cycles <= 4'd5;
    apb(1'b1, INSTR_OFF, mk(5'd6, 5'd4, 5'd5, XO_LOAD, 1'b0));
    run(mk(5'd9, 5'd4, 5'd5, XO_LOAD_UPD, 1'b0));
    gpr_chk(6, ~32'h0000_0240, "plain load sum");
    gpr_chk(9, ~32'h0000_0240, "update load target");
    gpr_chk(4, 32'h0000_0240, "base updated");
    // Invalid update forms load the target only
    run(mk(5'd4, 5'd4, 5'd5, XO_LOAD_UPD, 1'b0));
    gpr_chk(4, ~32'h0000_0280, "base equals target");
    run(mk(5'd7, 5'd0, 5'd5, XO_LOAD_UPD, 1'b0));
    gpr_chk(7, ~32'h0000_0040, "update base zero");
    gpr_chk(0, 32'h0000_0f00, "register zero kept");
    // Storage fault, then misaligned address: no writes at all
    set_gpr(4, 32'h0000_0300);
    fail_next <= 1'b1;
    run(mk(5'd8, 5'd4, 5'd5, XO_LOAD_UPD, 1'b0));
    fail_next <= 1'b0;
    rd_chk(STATUS_OFF, 32'h0000_0008, "storage fault flag");
    apb(1'b1, STATUS_OFF, 32'h0000_0008);
    set_gpr(5, 32'h0000_0041);
    run(mk(5'd8, 5'd4, 5'd5, XO_LOAD_UPD, 1'b0));
    rd_chk(STATUS_OFF, 32'h0000_0004, "alignment flag");
    apb(1'b1, STATUS_OFF, 32'h0000_0004);
    gpr_chk(4, 32'h0000_0300, "base kept on fault");
    gpr_chk(8, 32'h0000_0000, "target kept on fault");
    rd_chk(COND_OFF, 32'h0000_0109, "loads keep cond");
    // Mask generate and insert, record flag on odd entries
    for (i = 0; i < 10; i++) begin
      pre = i[1] ? 32'h0000_0105 : 32'h0000_000a;
      so = pre[COND_SO_BIT];
      ec = i[0] ? {23'h00_0000, so, 4'h0, ev[i][31], !ev[i][31] && |ev[i], ~|ev[i], so} : pre;
      apb(1'b1, COND_OFF, pre);
      set_gpr(6, tv[i]);
      set_gpr(5, sv[i]);
      set_gpr(4, bv[i]);
      run(mk(5'd5, 5'd6, 5'd4, (i < 6) ? XO_MASK_GEN : XO_MASK_INS, i[0]));
      gpr_chk(6, ev[i], "mask result");
      rd_chk(COND_OFF, ec, "mask cond");
    end
    // Mask generation is refused outside the legacy variant
    apb(1'b1, CTRL_OFF, 32'h0000_0000);
    run(mk(5'd5, 5'd6, 5'd4, XO_MASK_GEN, 1'b1));
    gpr_chk(6, 32'h0000_0000, "newer variant target kept");
    rd_chk(STATUS_OFF, 32'h0000_0002, "illegal flag");
    apb(1'b1, STATUS_OFF, 32'h0000_0002);
    apb(1'b1, CTRL_OFF, 32'h0000_0001);
    run(mk(5'd5, 5'd6, 5'd4, XO_MASK_GEN, 1'b0));
    gpr_chk(6, 32'h8000_0000, "legacy variant mask");
    // A foreign primary opcode with a load extended code must not load
    run({6'h20, 5'd6, 5'd0, 5'd5, XO_LOAD, 1'b0});
    rd_chk(STATUS_OFF, 32'h0000_0002, "foreign opcode refused");
    gpr_chk(6, 32'h8000_0000, "foreign opcode target kept");
    conclude();
  end
endmodule : tb
